// *** hw/coproc_pkg.sv ***
// Shared constants, field layouts and types for coprocessor instruction handling.
`default_nettype none
package coproc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte offsets on the register bus)
    // ------------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam logic [3:0] MASK_OFS = 4'h8;
    localparam logic [3:0] ADDR_OFS = 4'hc;

    localparam int unsigned CTRL_XFER_EN_BIT  = 0;
    localparam int unsigned CTRL_LATE_ABT_BIT = 1;
    localparam logic [1:0]  CTRL_RST          = 2'h0;

    // Event bits, identical layout in status and mask.
    localparam int unsigned EV_UNDEF = 0;
    localparam int unsigned EV_ABORT = 1;
    localparam int unsigned EV_COPROC_REGISTER_TRANSFER  = 2;
    localparam int unsigned EV_DONE  = 3;
    localparam int unsigned EV_W     = 4;
    localparam logic [3:0]  EV_RST   = 4'h0;

    // ------------------------------------------------------------------
    // Instruction encoding
    // ------------------------------------------------------------------
    localparam logic [3:0]  CP_OP_CLASS   = 4'he;   // Bits 27:24.
    localparam logic [2:0]  CP_LDST_CLASS = 3'h6;   // Bits 27:25.
    localparam logic [3:0]  CTRL_CP_NUM   = 4'hf;
    localparam logic [3:0]  PC_REG        = 4'hf;
    localparam logic [31:0] PC_AHEAD      = 32'h8;
    localparam logic [31:0] WORD_STEP     = 32'h4;
    localparam int unsigned IMM_SHIFT     = 2;

    // Fields of a coprocessor load or store.
    typedef struct packed {
        logic       pre;
        logic       up;
        logic       len;
        logic       wback;
        logic       load;
        logic [3:0] base_register;
        logic [3:0] coproc_dest_reg;
        logic [3:0] coproc_number_field;
        logic [7:0] imm;
    } ldst_s;

    // Address generator results.
    typedef struct packed {
        logic [31:0] first;
        logic [31:0] new_base;
    } addr_s;

    typedef enum logic {ST_IDLE, ST_XFER} state_e;

endpackage : coproc_pkg
`default_nettype wire

// *** hw/cond_check.sv ***
// Condition field evaluation against the current flags.
`timescale 1ns/1ps
`default_nettype none
module cond_check (
    input  wire logic [3:0] cond_i,
    input  wire logic [3:0] flags_i,
    output logic            pass_o
);

    // ------------------------------------------------------------------
    // Flag split, order N Z C V from bit 3 down.
    // ------------------------------------------------------------------
    wire n_f = flags_i[3];
    wire z_f = flags_i[2];
    wire c_f = flags_i[1];
    wire v_f = flags_i[0];

    // Condition code 4'hf never passes, so such words act as no-ops.
    always_comb begin
        case (cond_i)
            4'h0:    pass_o = z_f;
            4'h1:    pass_o = !z_f;
            4'h2:    pass_o = c_f;
            4'h3:    pass_o = !c_f;
            4'h4:    pass_o = n_f;
            4'h5:    pass_o = !n_f;
            4'h6:    pass_o = v_f;
            4'h7:    pass_o = !v_f;
            4'h8:    pass_o = c_f && !z_f;
            4'h9:    pass_o = !c_f || z_f;
            4'ha:    pass_o = n_f == v_f;
            4'hb:    pass_o = n_f != v_f;
            4'hc:    pass_o = !z_f && (n_f == v_f);
            4'hd:    pass_o = z_f || (n_f != v_f);
            4'he:    pass_o = 1'b1;
            default: pass_o = 1'b0;
        endcase
    end

endmodule : cond_check
`default_nettype wire

// *** hw/coproc_addr_gen.sv ***
// Address generation for coprocessor loads and stores.
`timescale 1ns/1ps
`default_nettype none
module coproc_addr_gen (
    input  wire coproc_pkg::ldst_s f_i,
    input  wire logic [31:0]       base_i,
    input  wire logic [31:0]       pc_i,
    output coproc_pkg::addr_s      a_o
);

    // ------------------------------------------------------------------
    // Base selection and offset arithmetic
    // ------------------------------------------------------------------
    // The program counter reads eight ahead of the current instruction.
    wire is_pc = f_i.base_register == coproc_pkg::PC_REG;
    wire [31:0] base_val = is_pc ? pc_i + coproc_pkg::PC_AHEAD
                                 : base_i; // RULE_15
    // Word offset scaled to bytes; zero-extended, never sign-extended.
    wire [31:0] offs = {22'h0, f_i.imm, 2'h0}; // RULE_10
    wire [31:0] moved = f_i.up ? base_val + offs
                               : base_val - offs; // RULE_10

    // Pre-indexing uses the moved base; low bits pass through unchanged.
    assign a_o.first    = f_i.pre ? moved : base_val; // RULE_11 RULE_14
    assign a_o.new_base = moved;

endmodule : coproc_addr_gen
`default_nettype wire

// *** hw/coproc_insn_handler.sv ***
// Coprocessor instruction classing, trapping and transfer sequencing.
//
// Functional notes
// RULE_01: Only coprocessor 15 register transfers execute.
// RULE_02: All other coprocessor instructions take undefined trap; code runs loads and stores when transfer-enable bit set.
// RULE_03: Failed condition makes the instruction a no-op.
// RULE_04: Data operations never wait nor return results.
// RULE_05: Decode data operations from bits 31:24, 4.
// RULE_06: Coprocessors ignore instructions with other numbers.
// RULE_07: Coprocessor defines data operation on its registers.
// RULE_08: Processor gives addresses; coprocessor sets word count.
// RULE_09: Length bit picks one of two lengths.
// RULE_10: Immediate times four, added or subtracted.
// RULE_11: Pre-index applies offset before first address.
// RULE_12: Write back base only when write-back bit set.
// RULE_13: First word at base, then four up.
// RULE_14: Low two address bits driven unchanged.
// RULE_15: Program counter base reads current plus eight.
// RULE_16: Abort takes data trap, base still written.
// RULE_17: Late-abort bit never changes abort behaviour.
// RULE_18: Coprocessor keeps aborted transfers restartable.
//
// Register access over Wishbone and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module coproc_insn_handler (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register bus, classic Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    // Instruction issue from the core pipeline.
    input  wire logic        insn_valid_i,
    input  wire logic [31:0] insn_i,
    input  wire logic [3:0]  flags_i,
    input  wire logic [31:0] pc_i,
    input  wire logic [31:0] base_i,
    output logic             insn_ready_o,
    output logic             undef_trap_o,
    output logic             reg_xfer_go_o,
    output logic             abort_trap_o,
    output logic             base_wr_o,
    output logic [3:0]       base_wr_reg_o,
    output logic [31:0]      base_wr_val_o,
    // Data bus towards memory and memory manager.
    output logic             mem_req_o,
    output logic [31:0]      mem_addr_o,
    output logic             mem_we_o,
    output logic             mem_len_o,
    output logic [3:0]       mem_cp_reg_o,
    input  wire logic        mem_ack_i,
    input  wire logic        mem_abort_i,
    input  wire logic        cp_last_i
);

    // ------------------------------------------------------------------
    // Field extraction
    // ------------------------------------------------------------------
    function automatic coproc_pkg::ldst_s ldst_fields(input logic [31:0] w);
        ldst_fields.pre                 = w[24];
        ldst_fields.up                  = w[23];
        ldst_fields.len                 = w[22];
        ldst_fields.wback               = w[21];
        ldst_fields.load                = w[20];
        ldst_fields.base_register       = w[19:16];
        ldst_fields.coproc_dest_reg     = w[15:12];
        ldst_fields.coproc_number_field = w[11:8];
        ldst_fields.imm                 = w[7:0];
    endfunction : ldst_fields

    // ------------------------------------------------------------------
    // Instruction classing
    // ------------------------------------------------------------------
    // Data operation and register transfer share bits 27:24 and differ
    // only in bit 4; nothing else of the word is looked at for them.
    wire cp_op_class = insn_i[27:24] == coproc_pkg::CP_OP_CLASS;
    wire is_data_op  = cp_op_class && !insn_i[4]; // RULE_05
    wire is_reg_xfer = cp_op_class && insn_i[4];
    wire is_ldst     = insn_i[27:25] == coproc_pkg::CP_LDST_CLASS;
    wire to_ctrl_cp  = insn_i[11:8] == coproc_pkg::CTRL_CP_NUM;
    wire is_cp_insn  = is_data_op || is_reg_xfer || is_ldst;

    coproc_pkg::ldst_s fld;
    coproc_pkg::addr_s agen;
    logic              cond_ok;

    assign fld = ldst_fields(insn_i);

    cond_check u_cond (
        .cond_i  (insn_i[31:28]),
        .flags_i (flags_i),
        .pass_o  (cond_ok)
    );

    coproc_addr_gen u_agen (
        .f_i    (fld),
        .base_i (base_i),
        .pc_i   (pc_i),
        .a_o    (agen)
    );

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    coproc_pkg::state_e state_r;
    coproc_pkg::state_e state_nxt;
    logic [1:0]         ctrl_r;
    logic [3:0]         stat_r;
    logic [3:0]         mask_r;
    logic [31:0]        last_addr_r;
    logic               wb_b_r;
    logic [3:0]         wb_reg_r;
    logic [31:0]        new_base_r;

    // ------------------------------------------------------------------
    // Issue decisions
    // ------------------------------------------------------------------
    assign insn_ready_o = state_r == coproc_pkg::ST_IDLE;

    wire take     = insn_valid_i && insn_ready_o && is_cp_insn;
    // Only a taken instruction whose condition holds has any effect.
    wire live     = take && cond_ok; // RULE_03
    wire xfer_en  = ctrl_r[coproc_pkg::CTRL_XFER_EN_BIT];
    wire do_reg   = live && is_reg_xfer && to_ctrl_cp; // RULE_01
    // Loads and stores run only in the debug transfer mode.
    wire do_ldst  = live && is_ldst && xfer_en;
    // Data operations trap at once: no completion is awaited.
    wire do_undef = live && !do_reg && !do_ldst; // RULE_02 RULE_04
    // Base write-back is refused for the program counter.
    wire wb_ok    = fld.wback && fld.base_register != coproc_pkg::PC_REG;

    // ------------------------------------------------------------------
    // Transfer sequencing
    // ------------------------------------------------------------------
    // The coprocessor decides the length through cp_last_i.
    wire word_ok  = mem_req_o && mem_ack_i && !mem_abort_i;
    wire xfer_end = word_ok && cp_last_i; // RULE_08
    // Late-abort control is never consulted on this path.
    wire xfer_abt = mem_req_o && mem_abort_i; // RULE_17
    wire finish   = xfer_end || xfer_abt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            coproc_pkg::ST_IDLE: begin
                if (do_ldst) begin
                    state_nxt = coproc_pkg::ST_XFER;
                end
            end
            coproc_pkg::ST_XFER: begin
                if (finish) begin
                    state_nxt = coproc_pkg::ST_IDLE;
                end
            end
            default: state_nxt = coproc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= coproc_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Memory request: first address from the generator, then one word up.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_req_o    <= 1'b0;
            mem_addr_o   <= 32'h0;
            mem_we_o     <= 1'b0;
            mem_len_o    <= 1'b0;
            mem_cp_reg_o <= 4'h0;
        end else if (do_ldst) begin
            mem_req_o    <= 1'b1;
            mem_addr_o   <= agen.first; // RULE_13 RULE_14
            mem_we_o     <= !fld.load;
            mem_len_o    <= fld.len;
            mem_cp_reg_o <= fld.coproc_dest_reg;
        end else if (finish) begin
            mem_req_o    <= 1'b0;
        end else if (word_ok) begin
            mem_addr_o   <= mem_addr_o + coproc_pkg::WORD_STEP; // RULE_13
        end
    end

    // Base write-back is held until the transfer ends or aborts.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_b_r     <= 1'b0;
            wb_reg_r   <= 4'h0;
            new_base_r <= 32'h0;
        end else if (do_ldst) begin
            wb_b_r     <= wb_ok; // RULE_12 RULE_15
            wb_reg_r   <= fld.base_register;
            new_base_r <= agen.new_base;
        end
    end

    // Result pulses, each one cycle wide.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            undef_trap_o  <= 1'b0;
            reg_xfer_go_o <= 1'b0;
            abort_trap_o  <= 1'b0;
            base_wr_o     <= 1'b0;
        end else begin
            undef_trap_o  <= do_undef; // RULE_02
            reg_xfer_go_o <= do_reg; // RULE_01
            abort_trap_o  <= xfer_abt; // RULE_16
            base_wr_o     <= finish && wb_b_r; // RULE_12 RULE_16
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            base_wr_reg_o <= 4'h0;
            base_wr_val_o <= 32'h0;
        end else if (finish) begin
            base_wr_reg_o <= wb_reg_r;
            base_wr_val_o <= new_base_r;
        end
    end

    // ------------------------------------------------------------------
    // Register bus decode
    // ------------------------------------------------------------------
    wire       bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       bus_wr   = bus_req && wb_we_i;
    wire       sel_ctrl = wb_adr_i == coproc_pkg::CTRL_OFS;
    wire       sel_stat = wb_adr_i == coproc_pkg::STAT_OFS;
    wire       sel_mask = wb_adr_i == coproc_pkg::MASK_OFS;
    wire       sel_addr = wb_adr_i == coproc_pkg::ADDR_OFS;
    // All writable fields sit in byte lane 0.
    wire       lane0    = wb_sel_i[0];
    wire [3:0] ev_set   = {xfer_end, do_reg, xfer_abt, do_undef};
    wire [3:0] ev_clr   = (bus_wr && sel_stat && lane0) ? wb_dat_i[3:0]
                                                        : 4'h0;

    wire [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl_r}
                       : sel_stat ? {28'h0, stat_r}
                       : sel_mask ? {28'h0, mask_r}
                       : sel_addr ? last_addr_r
                       : 32'h0;

    // Answer one cycle after the strobe; unmapped reads return zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= rd_mux;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= coproc_pkg::CTRL_RST;
            mask_r <= coproc_pkg::EV_RST;
        end else if (bus_wr && lane0) begin
            if (sel_ctrl) begin
                ctrl_r <= wb_dat_i[1:0];
            end
            if (sel_mask) begin
                mask_r <= wb_dat_i[3:0];
            end
        end
    end

    // Sticky events: a new event in the clear cycle survives the clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_r <= coproc_pkg::EV_RST;
        end else begin
            stat_r <= (stat_r & ~ev_clr) | ev_set;
        end
    end

    // Last address presented on the data bus, for the abort handler.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            last_addr_r <= 32'h0;
        end else if (mem_req_o) begin
            last_addr_r <= mem_addr_o;
        end
    end

    assign irq_o = |(stat_r & mask_r);

endmodule : coproc_insn_handler
`default_nettype wire

// *** testbench/coproc_props.sv ***
// Port-level checker for the coprocessor instruction handler.
`timescale 1ns/1ps
`default_nettype none
module coproc_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        insn_valid_i,
    input wire logic [31:0] insn_i,
    input wire logic        insn_ready_o,
    input wire logic        undef_trap_o,
    input wire logic        reg_xfer_go_o,
    input wire logic        abort_trap_o,
    input wire logic        mem_req_o,
    input wire logic [31:0] mem_addr_o,
    input wire logic        mem_ack_i,
    input wire logic        mem_abort_i,
    input wire logic        cp_last_i
);
    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    // Only always and never conditions are judged, flags need no model.
    wire logic take = insn_valid_i && insn_ready_o;
    wire logic cpop = take && insn_i[27:24] == 4'he;
    wire logic yes  = cpop && insn_i[31:28] == 4'he;
    wire logic hit  = mem_req_o && mem_ack_i && !mem_abort_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_dataop_trap: assert property (
        yes && !insn_i[4] |=> undef_trap_o && !reg_xfer_go_o)
        else $error("data operation did not trap");
    a_cp15_xfer: assert property (
        yes && insn_i[4] && insn_i[11:8] == 4'hf
        |=> reg_xfer_go_o && !undef_trap_o)
        else $error("register transfer not executed");
    a_never_noop: assert property (
        cpop && insn_i[31:28] == 4'hf |=> !undef_trap_o && !reg_xfer_go_o)
        else $error("failed condition had an effect");
    a_word_step: assert property (
        hit && !cp_last_i
        |=> mem_req_o && mem_addr_o == $past(mem_addr_o) + 32'h4)
        else $error("next word address not four above");
    a_last_ends: assert property (
        hit && cp_last_i |=> !mem_req_o && insn_ready_o)
        else $error("transfer did not end on last word");
    a_abort_trap: assert property (
        mem_req_o && mem_abort_i |=> abort_trap_o && !mem_req_o)
        else $error("abort did not trap");
    a_req_holds: assert property (
        mem_req_o && !mem_ack_i && !mem_abort_i
        |=> mem_req_o && $stable(mem_addr_o))
        else $error("request changed before answer");
    a_busy_refuse: assert property (
        mem_req_o |-> !insn_ready_o)
        else $error("ready during transfer");
    a_wb_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not one cycle");
    c_abort: cover property (mem_req_o && mem_abort_i);
    c_multi: cover property (hit && !cp_last_i);
    c_xfer: cover property (reg_xfer_go_o);
endmodule : coproc_props
bind coproc_insn_handler coproc_props u_props (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .insn_valid_i, .insn_i, .insn_ready_o,
    .undef_trap_o, .reg_xfer_go_o, .abort_trap_o, .mem_req_o, .mem_addr_o,
    .mem_ack_i, .mem_abort_i, .cp_last_i);
`default_nettype wire

// *** testbench/mem_model.sv ***
// Memory system and coprocessor word-count model on the data bus.
`timescale 1ns/1ps
`default_nettype none
module mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        we_i,
    input  wire logic        len_i,
    output logic             ack_o,
    output logic             abort_o,
    output logic             last_o
);
    int          delay    = 0;
    int          words    = 1;
    int          abort_at = -1;
    int          cnt;
    int          idx;
    logic [31:0] seen[$];
    logic        seen_we;
    logic        seen_len;
    // Answers each word after a delay; last toggles when unqualified so
    // a design that reads it without ack is caught.
    always @(posedge clk_i) begin
        ack_o   <= 1'b0;
        abort_o <= 1'b0;
        last_o  <= ~last_o;
        if (rst_i || !req_i) begin
            cnt    <= 0;
            idx    <= 0;
            last_o <= 1'b0;
        end else if (!ack_o && !abort_o) begin
            if (cnt < delay) begin
                cnt <= cnt + 1;
            end else begin
                cnt <= 0;
                idx <= idx + 1;
                seen.push_back(addr_i);
                seen_we  <= we_i;
                seen_len <= len_i;
                if (idx == abort_at) begin
                    abort_o <= 1'b1;
                end else begin
                    ack_o  <= 1'b1;
                    last_o <= (idx == words - 1);
                end
            end
        end
    end
endmodule : mem_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking testbench for the coprocessor instruction handler.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_i, rst_i, cyc, stb, we, ival;
    logic [3:0]  adr, flags, sel;
    logic [31:0] dat, insn, pc, base, q, r, nb, np;
    logic        gu, gx, ga, gb, gm;
    logic [31:0] bv;
    logic [3:0]  br;
    wire logic [31:0] dat_o, bwr_val, maddr;
    wire logic [3:0]  bwr_reg, mcr;
    wire logic        ack, irq, rdy, und, rxg, abt, bwr, mreq, mwe, mlen;
    wire logic        mack, mabt, mlast;
    int               mismatches, n_tests;
    coproc_insn_handler dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_o(irq),
        .insn_valid_i(ival), .insn_i(insn), .flags_i(flags), .pc_i(pc),
        .base_i(base), .insn_ready_o(rdy), .undef_trap_o(und),
        .reg_xfer_go_o(rxg), .abort_trap_o(abt), .base_wr_o(bwr),
        .base_wr_reg_o(bwr_reg), .base_wr_val_o(bwr_val),
        .mem_req_o(mreq), .mem_addr_o(maddr), .mem_we_o(mwe),
        .mem_len_o(mlen), .mem_cp_reg_o(mcr), .mem_ack_i(mack),
        .mem_abort_i(mabt), .cp_last_i(mlast));
    mem_model mem_u (.clk_i, .rst_i, .req_i(mreq), .addr_i(maddr),
        .we_i(mwe), .len_i(mlen), .ack_o(mack), .abort_o(mabt),
        .last_o(mlast));
    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task print_verdict;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // One classic bus cycle; the wait is bounded by the bench only.
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        for (k = 0; k < 50; k++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        q = dat_o;
        {cyc, stb} <= 2'b00;
        if (k == 50) begin
            mismatches++;
            print_verdict;
        end
    endtask : wb
    // Offers one word and gathers every pulse until the block is idle.
    task issue(input logic [31:0] w, input logic [3:0] f);
        int k;
        @(posedge clk_i);
        {ival, insn, flags, base, pc} <= {1'b1, w, f, nb, np};
        @(posedge clk_i);
        ival <= 1'b0;
        {gu, gx, ga, gb, gm} = 5'h0;
        for (k = 0; k < 100; k++) begin
            @(negedge clk_i);
            {gu, gx, ga, gm} = {gu | und, gx | rxg, ga | abt, gm | mreq};
            if (bwr) {gb, bv, br} = {1'b1, bwr_val, bwr_reg};
            if (rdy === 1'b1) break;
        end
        if (k == 100) begin
            mismatches++;
            print_verdict;
        end
    endtask : issue
    // Load or store with the address sequence worked out independently.
    task ldst(input logic [4:0] pulwn, input logic [3:0] bn,
              input logic [7:0] imm, input int words, input int ab);
        logic [31:0] b, m, f;
        b = (bn == 4'hf) ? np + 32'h8 : nb;
        m = pulwn[3] ? b + {22'h0, imm, 2'h0} : b - {22'h0, imm, 2'h0};
        f = pulwn[4] ? m : b;
        mem_u.seen.delete();
        {mem_u.words, mem_u.abort_at} = {words, ab};
        mem_u.delay = $urandom_range(0, 2);
        issue({4'he, 3'b110, pulwn[4:3], pulwn[0], pulwn[1], pulwn[2], bn,
               8'h3f, imm}, 4'h0);
        check(32'(ga), 32'(ab >= 0));
        check(32'(gb), 32'(pulwn[1] && bn != 4'hf));
        if (gb) check({br, bv[27:0]}, {bn, m[27:0]});
        if (gb) check(bv, m);
        check(32'(mcr), 32'h3);
        check(32'(mem_u.seen.size()),
              32'(ab >= 0 ? ab + 1 : words));
        foreach (mem_u.seen[i]) begin
            check(mem_u.seen[i], f + 32'(4 * i));
        end
        check(32'({mem_u.seen_we, mem_u.seen_len}),
              32'({~pulwn[2], pulwn[0]}));
        wb(1'b0, 4'hc, 32'h0);
        check(q, mem_u.seen[$]);
    endtask : ldst
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        {cyc, stb, we, ival, adr, flags, dat, insn, pc, base} = '0;
        {nb, np, mismatches, n_tests} = '0;
        sel = 4'hf;
        rst_i = 1'b1;
        void'($urandom(36869));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b1, 4'hc, 32'hffffffff);
        wb(1'b1, 4'h2, 32'hffffffff);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, (i < 4) ? 4'(i * 4) : 4'h2, 32'h0);
            check(q, 32'h0);
        end
        $display("register reset test done");
        repeat (8) begin
            r = $urandom;
            issue({4'he, 4'he, r[23:5], 1'b0, r[3:0]}, r[31:28]);
            check(32'({gu, gx, gm}), 32'h4);
        end
        @(negedge clk_i) check(32'(irq), 32'h0);
        wb(1'b1, 4'h8, 32'h1);
        @(negedge clk_i) check(32'(irq), 32'h1);
        wb(1'b1, 4'h4, 32'h1);
        @(negedge clk_i) check(32'(irq), 32'h0);
        wb(1'b0, 4'h4, 32'h0);
        check(q, 32'h0);
        sel <= 4'he;
        wb(1'b1, 4'h8, 32'h0);
        sel <= 4'hf;
        wb(1'b0, 4'h8, 32'h0);
        check(q, 32'h1);
        $display("data operation and interrupt test done");
        for (int cp = 0; cp < 16; cp++) begin
            r = $urandom;
            issue({4'he, 4'he, r[23:12], 4'(cp), r[7:5], 1'b1, r[3:0]}, 4'h0);
            check(32'({gx, gu}),
                  (cp == 15) ? 32'h2 : 32'h1);
        end
        for (int z = 0; z < 2; z++) begin
            issue({4'h0, 4'he, 24'h000f10}, {1'b0, 1'(z), 2'h0});
            check(32'(gx), 32'(z));
            issue({4'hf, 4'he, 24'h000f10}, 4'hf);
            check(32'({gx, gu}), 32'h0);
        end
        issue({4'he, 3'b110, 25'h1a00301}, 4'h0);
        check(32'({gu, gm}), 32'h2);
        $display("condition and class test done");
        for (int c = 1; c < 4; c += 2) begin
            wb(1'b1, 4'h0, 32'(c));
            repeat (6) begin
                {r, nb, np} = {$urandom, $urandom, $urandom};
                ldst(r[4:0], r[11:8], r[19:12], $urandom_range(1, 3), -1);
            end
            ldst(5'b10010, 4'h2, 8'hff, 2, -1);
            ldst(5'b01011, 4'hf, 8'h01, 1, -1);
            ldst(5'b11010, 4'h3, 8'h10, 3, 1);
            ldst(5'b11010, 4'h3, 8'h10, 3, -1);
        end
        wb(1'b0, 4'h4, 32'h0);
        check(q, 32'hf);
        $display("transfer and abort test done");
        print_verdict;
    end
endmodule : tb_top
`default_nettype wire
